// [rtl/lwk_pkg.sv]
package lwk_pkg;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_LENGTH = 12'h008;
  localparam logic [11:0] OFF_ADDR_LO = 12'h00C;
  localparam logic [11:0] OFF_ADDR_HI = 12'h010;
  localparam logic [11:0] OFF_PMCSR = 12'h014;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;
  localparam logic [11:0] OFF_MEM_BASE = 12'h100;
  localparam logic [11:0] OFF_MEM_LAST = 12'h17C;

  // Field positions
  localparam int CTRL_WAKE_EN = 0;
  localparam int CTRL_PME_EN = 1;
  localparam int STAT_PATTERN = 0;
  localparam int PMCSR_PME_STATUS = 15;
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_PME = 1;
  localparam int IRQ_BITS = 2;

  // Values after reset
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;

  // Wake pattern shape: sync run, then the station address repeated
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_COUNT = 3'h6;
  localparam logic [6:0] BODY_BYTES = 7'h60;
  localparam logic [2:0] ADDR_BYTES = 3'h6;
  localparam int CAPTURE_BYTES = 128;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic maint;
    logic [7:0] data;
  } lwk_rx_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT_LINK = 3'b010,
    ST_SEND = 3'b100
  } lwk_pme_e;

endpackage

// [rtl/lwk_wakeup.sv]
// What this block does
// - Pull wake request low on every filter match
// - Power-up copies EEPROM wake enable into control
// - Screen every packet while wakeup enabled
// - PME enabled: set PME status, send message
// - Keep first 128 bytes of matching packet
// - Match sets wake pattern received flag
// - Match writes packet length register
// - First match held until flag written one
// - Enable only cleared by power-on reset, EEPROM or software
// - Config survives soft-off; soft-off clears data
// - Maintenance port packets never wake
`timescale 1ns/1ps
`default_nettype none

module lwk_wakeup #(
  parameter int LEN_W = 16
) (
  input wire logic core_clk, // 100 MHz
  input wire logic rst_n, // Power-on reset, sync
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire lwk_pkg::lwk_rx_s rx, // Received byte stream
  input wire logic eepromLoad, // EEPROM word read done
  input wire logic eepromWakeEn, // Enable bit of that word
  input wire logic linkUp, // Link has power and clock
  input wire logic softOffPin, // Platform entering soft-off
  output logic mac_wake_request_n, // Wake pin, active low
  output logic pmeMsg, // PM_PME message request
  output logic irq // Level interrupt
);

  ////////////////////////////////////////////////////////////////
  // Registers

  logic [1:0] wakeup_control_reg;
  logic wake_pattern_received_flag;
  logic [LEN_W-1:0] wakeup_packet_length_reg;
  logic [47:0] stationAddr;
  logic pmeStatus;
  logic [lwk_pkg::IRQ_BITS-1:0] irqStat;
  logic [lwk_pkg::IRQ_BITS-1:0] irqMask;
  logic packet_wakeup_enable_bit;
  logic pme_on_wakeup_enable;

  // Two banks so a failed capture never disturbs the kept packet
  logic [7:0] wakeup_packet_memory [2*lwk_pkg::CAPTURE_BYTES];
  logic bank;

  assign packet_wakeup_enable_bit = wakeup_control_reg[lwk_pkg::CTRL_WAKE_EN];
  assign pme_on_wakeup_enable = wakeup_control_reg[lwk_pkg::CTRL_PME_EN];

  ////////////////////////////////////////////////////////////////
  // APB decode

  logic setup;
  logic wrDone;
  logic rdDone;
  logic isMem;

  assign setup = psel && !penable;
  assign wrDone = psel && penable && pready && pwrite;
  assign rdDone = psel && penable && pready && !pwrite;
  assign isMem = (paddr >= lwk_pkg::OFF_MEM_BASE) && (paddr <= lwk_pkg::OFF_MEM_LAST);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    return hit(a, lwk_pkg::OFF_CTRL) || hit(a, lwk_pkg::OFF_STATUS) || hit(a, lwk_pkg::OFF_LENGTH)
      || hit(a, lwk_pkg::OFF_ADDR_LO) || hit(a, lwk_pkg::OFF_ADDR_HI) || hit(a, lwk_pkg::OFF_PMCSR)
      || hit(a, lwk_pkg::OFF_IRQ_STAT) || hit(a, lwk_pkg::OFF_IRQ_MASK)
      || ((a >= lwk_pkg::OFF_MEM_BASE) && (a <= lwk_pkg::OFF_MEM_LAST) && (a[1:0] == 2'h0));
  endfunction

  logic [31:0] next_rdata;
  logic [6:0] memByte;

  always_comb
  begin
    memByte = {paddr[6:2], 2'h0};
    next_rdata = 32'h0000_0000;
    if (isMem)
    begin
      next_rdata = {wakeup_packet_memory[{bank, memByte + 7'h3}], wakeup_packet_memory[{bank, memByte + 7'h2}],
                    wakeup_packet_memory[{bank, memByte + 7'h1}], wakeup_packet_memory[{bank, memByte}]};
    end
    else
    begin
      case (paddr)
        lwk_pkg::OFF_CTRL: next_rdata = {30'h0, wakeup_control_reg};
        lwk_pkg::OFF_STATUS: next_rdata = {31'h0, wake_pattern_received_flag};
        lwk_pkg::OFF_LENGTH: next_rdata = 32'(wakeup_packet_length_reg);
        lwk_pkg::OFF_ADDR_LO: next_rdata = stationAddr[31:0];
        lwk_pkg::OFF_ADDR_HI: next_rdata = {16'h0, stationAddr[47:32]};
        lwk_pkg::OFF_PMCSR: next_rdata = 32'(pmeStatus) << lwk_pkg::PMCSR_PME_STATUS;
        lwk_pkg::OFF_IRQ_STAT: next_rdata = {30'h0, irqStat};
        lwk_pkg::OFF_IRQ_MASK: next_rdata = {30'h0, irqMask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // One fixed wait-free access: ready rises for the first access cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      // Error flag stands only beside ready, never after
      pslverr <= setup && !mapped(paddr);
      if (setup)
      begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Soft-off pin: three flops, counts once second and third agree

  logic [2:0] offSync;
  logic softOff;
  logic softOffPrev;
  logic softOffEntry;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      offSync <= 3'h0;
      softOff <= 1'b0;
      softOffPrev <= 1'b0;
    end
    else
    begin
      offSync <= {offSync[1:0], softOffPin};
      if (offSync[1] == offSync[2])
      begin
        softOff <= offSync[2];
      end
      softOffPrev <= softOff;
    end
  end

  assign softOffEntry = softOff && !softOffPrev;

  ////////////////////////////////////////////////////////////////
  // Wake pattern matcher

  logic [2:0] syncCnt;
  logic inBody;
  logic [6:0] bodyIdx;
  logic [2:0] addrIdx;
  logic matched;
  logic [LEN_W-1:0] byteCnt;
  logic [2:0] curSync;
  logic curBody;
  logic curMatched;
  logic [6:0] curIdx;
  logic [2:0] curAddr;
  logic [LEN_W-1:0] curCnt;
  logic byteTake;
  logic bodyHit;
  logic [7:0] expByte;

  function automatic logic [7:0] addrByte(input logic [47:0] a, input logic [2:0] i);
    return a[8*(5-i) +: 8];
  endfunction

  // Start of packet wipes the running state before the byte is judged
  always_comb
  begin
    curSync = rx.sop ? 3'h0 : syncCnt;
    curBody = rx.sop ? 1'b0 : inBody;
    curMatched = rx.sop ? 1'b0 : matched;
    curIdx = rx.sop ? 7'h0 : bodyIdx;
    curAddr = rx.sop ? 3'h0 : addrIdx;
    curCnt = rx.sop ? '0 : byteCnt;
    expByte = addrByte(stationAddr, curAddr);
    byteTake = rx.valid && packet_wakeup_enable_bit && !rx.maint;
    bodyHit = curBody && (rx.data == expByte) && (curIdx == lwk_pkg::BODY_BYTES - 7'h1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      syncCnt <= 3'h0;
      inBody <= 1'b0;
      bodyIdx <= 7'h0;
      addrIdx <= 3'h0;
      matched <= 1'b0;
      byteCnt <= '0;
    end
    else if (byteTake)
    begin
      byteCnt <= curCnt + 1'b1;
      matched <= curMatched || bodyHit;
      if (!curBody)
      begin
        if (rx.data == lwk_pkg::SYNC_BYTE)
        begin
          syncCnt <= (curSync == lwk_pkg::SYNC_COUNT - 3'h1) ? curSync : curSync + 3'h1;
          inBody <= curSync == lwk_pkg::SYNC_COUNT - 3'h1;
          bodyIdx <= 7'h0;
          addrIdx <= 3'h0;
        end
        else
        begin
          syncCnt <= 3'h0;
          inBody <= 1'b0;
        end
      end
      else if (rx.data == expByte)
      begin
        bodyIdx <= curIdx + 7'h1;
        addrIdx <= (curAddr == lwk_pkg::ADDR_BYTES - 3'h1) ? 3'h0 : curAddr + 3'h1;
        inBody <= !bodyHit;
        syncCnt <= 3'h0;
      end
      else if (rx.data == lwk_pkg::SYNC_BYTE && curIdx == 7'h0)
      begin
        inBody <= 1'b1;
      end
      else
      begin
        inBody <= 1'b0;
        syncCnt <= (rx.data == lwk_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Capture and commit

  logic matchEvent;

  // A miss only ever writes the spare bank, so the kept packet stands
  always_ff @(posedge core_clk)
  begin
    if (byteTake && !wake_pattern_received_flag && curCnt < LEN_W'(lwk_pkg::CAPTURE_BYTES))
    begin
      wakeup_packet_memory[{!bank, curCnt[6:0]}] <= rx.data;
    end
  end

  assign matchEvent = byteTake && rx.eop && (curMatched || bodyHit) && !wake_pattern_received_flag;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bank <= 1'b0;
      wakeup_packet_length_reg <= '0;
    end
    else if (matchEvent)
    begin
      bank <= !bank;
      wakeup_packet_length_reg <= curCnt + 1'b1;
    end
    else if (softOffEntry)
    begin
      wakeup_packet_length_reg <= '0;
    end
  end

  // Set beats a same-cycle write of one
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wake_pattern_received_flag <= 1'b0;
    end
    else if (matchEvent)
    begin
      wake_pattern_received_flag <= 1'b1;
    end
    else if (softOffEntry)
    begin
      wake_pattern_received_flag <= 1'b0;
    end
    else if (wrDone && hit(paddr, lwk_pkg::OFF_STATUS) && pwdata[lwk_pkg::STAT_PATTERN])
    begin
      wake_pattern_received_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control and address registers

  // Only power-on reset lands here; a system reset leaves it alone
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wakeup_control_reg <= lwk_pkg::CTRL_RESET;
      stationAddr <= lwk_pkg::STATION_RESET;
    end
    else
    begin
      if (eepromLoad)
      begin
        wakeup_control_reg[lwk_pkg::CTRL_WAKE_EN] <= eepromWakeEn;
      end
      else if (wrDone && hit(paddr, lwk_pkg::OFF_CTRL))
      begin
        wakeup_control_reg <= pwdata[1:0];
      end
      if (wrDone && hit(paddr, lwk_pkg::OFF_ADDR_LO))
      begin
        stationAddr[31:0] <= pwdata;
      end
      if (wrDone && hit(paddr, lwk_pkg::OFF_ADDR_HI))
      begin
        stationAddr[47:32] <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Wake pin and PME message

  lwk_pkg::lwk_pme_e pmeState;
  logic pmeSent;

  // Pin stays low until a software write of one or soft-off entry clears the received flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mac_wake_request_n <= 1'b1;
    end
    else if (matchEvent)
    begin
      mac_wake_request_n <= 1'b0;
    end
    else if (!wake_pattern_received_flag)
    begin
      mac_wake_request_n <= 1'b1;
    end
  end

  assign pmeSent = pmeState == lwk_pkg::ST_SEND;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pmeState <= lwk_pkg::ST_IDLE;
      pmeMsg <= 1'b0;
    end
    else
    begin
      pmeMsg <= 1'b0;
      case (pmeState)
        lwk_pkg::ST_IDLE:
        begin
          if (matchEvent && pme_on_wakeup_enable)
          begin
            pmeState <= linkUp ? lwk_pkg::ST_SEND : lwk_pkg::ST_WAIT_LINK;
          end
        end
        lwk_pkg::ST_WAIT_LINK:
        begin
          if (linkUp)
          begin
            pmeState <= lwk_pkg::ST_SEND;
          end
        end
        lwk_pkg::ST_SEND:
        begin
          pmeMsg <= 1'b1;
          pmeState <= lwk_pkg::ST_IDLE;
        end
        default: pmeState <= lwk_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pmeStatus <= 1'b0;
    end
    else if (matchEvent && pme_on_wakeup_enable)
    begin
      pmeStatus <= 1'b1;
    end
    else if (wrDone && hit(paddr, lwk_pkg::OFF_PMCSR) && pwdata[lwk_pkg::PMCSR_PME_STATUS])
    begin
      pmeStatus <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupts: sticky, cleared by read, set wins

  logic [lwk_pkg::IRQ_BITS-1:0] irqEvent;
  logic irqRead;

  assign irqEvent = {pmeSent, matchEvent};
  assign irqRead = rdDone && hit(paddr, lwk_pkg::OFF_IRQ_STAT);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irqStat <= '0;
      irqMask <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irqStat <= (irqRead ? '0 : irqStat) | irqEvent;
      if (wrDone && hit(paddr, lwk_pkg::OFF_IRQ_MASK))
      begin
        irqMask <= pwdata[lwk_pkg::IRQ_BITS-1:0];
      end
      irq <= |(((irqRead ? '0 : irqStat) | irqEvent) & irqMask);
    end
  end

endmodule

`default_nettype wire

// [tb/lwk_host_pm.sv]
`timescale 1ns/1ps
`default_nettype none
module lwk_host_pm #(
  parameter int LINK_DLY = 5
) (
  input wire logic core_clk, // Clock
  input wire logic sleep, // Bench puts link to sleep
  input wire logic mac_wake_request_n, // Wake pin from block
  input wire logic pmeMsg, // PME request from block
  output var logic linkUp = 1'b1, // Link power and clock
  output var int pmeCount = 0 // PME messages seen
);
  int cnt = 0;
  // Slow resume: while sleep is set, link returns only after the wake pin has been held
  always_ff @(posedge core_clk)
  begin
    cnt <= (!mac_wake_request_n && !linkUp) ? cnt + 1 : 0;
    linkUp <= !sleep || cnt == LINK_DLY || (linkUp && !mac_wake_request_n);
    if (pmeMsg)
      pmeCount <= pmeCount + 1;
  end
endmodule
`default_nettype wire

// [tb/lwk_wakeup_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lwk_wakeup_chk (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Sync reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire lwk_pkg::lwk_rx_s rx, // Rx stream
  input wire logic linkUp, // Link alive
  input wire logic mac_wake_request_n, // Wake pin
  input wire logic pmeMsg, // PME request
  input wire logic irq // Interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_pme_pulse: assert property (pmeMsg |=> !pmeMsg) else $error("PME request not a pulse");
  a_pme_link_up: assert property (pmeMsg |-> $past(linkUp, 2)) else $error("PME sent without link");
  a_wake_cause: assert property ($fell(mac_wake_request_n) |-> $past(rx.valid && rx.eop && !rx.maint))
    else $error("wake without packet end");
  a_maint_quiet: assert property (rx.valid && rx.eop && rx.maint && mac_wake_request_n |=> mac_wake_request_n)
    else $error("maintenance packet woke");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> mac_wake_request_n && !pmeMsg && !irq && !pready)
    else $error("outputs active in reset");
endmodule
bind lwk_wakeup lwk_wakeup_chk u_chk (.core_clk, .rst_n, .psel, .penable, .pready, .pslverr, .rx, .linkUp,
  .mac_wake_request_n, .pmeMsg, .irq);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst_n, psel, penable, pwrite, eepromLoad, eepromWakeEn, softOffPin, sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, linkUp, mac_wake_request_n, pmeMsg, irq, er, i0;
  lwk_pkg::lwk_rx_s rx;
  int pmeCount, err_count, cmp_count;
  localparam logic [47:0] STATION = 48'h0A0B_0C0D_0E0F;

  lwk_wakeup u_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx, .eepromLoad, .eepromWakeEn, .linkUp, .softOffPin, .mac_wake_request_n, .pmeMsg, .irq);
  lwk_host_pm u_host (.core_clk, .sleep, .mac_wake_request_n, .pmeMsg, .linkUp, .pmeCount);

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 50)
    begin
      err_count++;
      $display("MISMATCH t=%0t no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [7:0] pbyte(int i, bit bad);
    if (i < 6) return 8'hFF;
    if (i < 102) return (bad && i == 50) ? 8'h00 : STATION[47 - 8 * ((i - 6) % 6) -: 8];
    return 8'h55;
  endfunction

  task automatic send(input int n, input bit bad, input bit m);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      rx <= '{1'b1, i == 0, i == n - 1, m, pbyte(i, bad)};
    end
    @(posedge core_clk);
    rx <= '0;
    @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(lwk_pkg::OFF_CTRL, 32'h0);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, lwk_pkg::OFF_ADDR_LO, 32'h0C0D_0E0F);
    apb(1'b1, lwk_pkg::OFF_ADDR_HI, 32'h0000_0A0B);
    rdc(lwk_pkg::OFF_ADDR_HI, 32'h0000_0A0B);
    send(110, 1'b0, 1'b0);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, mac_wake_request_n}, 32'h1);
  endtask

  task automatic t_match;
    int n;
    n = 0;
    eepromWakeEn <= 1'b1;
    eepromLoad <= 1'b1;
    @(posedge core_clk);
    eepromLoad <= 1'b0;
    rdc(lwk_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, lwk_pkg::OFF_CTRL, 32'h3);
    sleep <= 1'b1;
    send(130, 1'b1, 1'b0);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
    send(130, 1'b0, 1'b0);
    chk({31'h0, mac_wake_request_n}, 32'h0);
    rdc(lwk_pkg::OFF_STATUS, 32'h1);
    rdc(lwk_pkg::OFF_LENGTH, 32'h82);
    rdc(lwk_pkg::OFF_MEM_BASE, 32'hFFFF_FFFF);
    rdc(lwk_pkg::OFF_MEM_BASE + 12'h8, 32'h0F0E_0D0C);
    rdc(lwk_pkg::OFF_MEM_LAST, 32'h5555_5555);
    while (pmeCount < 1 && n < 60)
    begin
      n++;
      @(posedge core_clk);
    end
    chk(32'(pmeCount), 32'h1);
    apb(1'b0, lwk_pkg::OFF_PMCSR, 32'h0);
    chk(rd & 32'h8000, 32'h8000);
    sleep <= 1'b0;
  endtask

  task automatic t_hold_irq;
    i0 = irq;
    apb(1'b1, lwk_pkg::OFF_IRQ_MASK, 32'h3);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, {31'h0, ~i0});
    apb(1'b0, lwk_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    send(110, 1'b0, 1'b0);
    rdc(lwk_pkg::OFF_LENGTH, 32'h82);
    apb(1'b1, lwk_pkg::OFF_STATUS, 32'h1);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, mac_wake_request_n}, 32'h1);
  endtask

  task automatic t_maint_soft;
    send(110, 1'b0, 1'b1);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
    send(110, 1'b0, 1'b0);
    rdc(lwk_pkg::OFF_STATUS, 32'h1);
    softOffPin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
    rdc(lwk_pkg::OFF_LENGTH, 32'h0);
    rdc(lwk_pkg::OFF_CTRL, 32'h3);
    softOffPin <= 1'b0;
    repeat (8) @(posedge core_clk);
    apb(1'b1, lwk_pkg::OFF_CTRL, 32'h0);
    send(110, 1'b0, 1'b0);
    rdc(lwk_pkg::OFF_STATUS, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rx = '0;
    eepromLoad = 1'b0;
    eepromWakeEn = 1'b0;
    softOffPin = 1'b0;
    sleep = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs;
    t_match;
    t_hold_irq;
    t_maint_soft;
    tally_and_finish;
  end

  // Whole run needs about a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
